// ==== logic/plwr_ctrl.sv ====
// Overview of operation
// - Long-pulse enable: 4 s low on resolved off
// - Mode 00 off, 01 on, 10 restore
// - Mode 11 uses software last-state flag
// - Last-state flag: 0 on, 1 off
// - On-return enable: 0.5 s low when on
// - Keyboard option: 0 sequence, 1 any key
// - Hunting arms wakes, cleared on capture
// - VOLTAGE_ID_LATCH, GPIO22/23 reset: bus or power-good
// - Supply-good gates power-good unless disabled
// - Mouse data-up plus selects choose event
// - Chassis clear bit clears intrusion status
// - First delay 300 or 200 ms
// - Second delay none, 32, 96, 250 ms
// - Retrigger drops then raises power-good, self-clears
// - Enables for second and third key sets
// - OS key wakes through power switch
// - Watchdog reset: bus or power-good
// - Monitor reset: power-good or bus
// - Wake flags latch, cleared on read
// - Data-up plus any-key: click or movement
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module plwr_ctrl
	import plwr_pkg::*;
#(
	parameter int LONG_CYC = LONG_PULSE_CYC,
	parameter int ON_CYC   = ON_PULSE_CYC,
	parameter int WAKE_CYC = WAKE_PULSE_CYC,
	parameter int D1S_CYC  = DLY1_SLOW_CYC,
	parameter int D1F_CYC  = DLY1_FAST_CYC,
	parameter int D2A_CYC  = DLY2_A_CYC,
	parameter int D2B_CYC  = DLY2_B_CYC,
	parameter int D2C_CYC  = DLY2_C_CYC
) (
	// Clock and resets
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          vbat_rst_n,
	// AXI4-Lite slave
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// Pins from the system
	input  wire logic          supply_good_in,
	input  wire logic          power_good_low_power_stage,
	input  wire logic          system_on_in,
	input  wire logic          standby_return_in,
	input  wire logic          bus_reset_in_n,
	input  wire logic          chassis_intrusion_in,
	// Keyboard and mouse event lines
	input  wire logic          kb_any_key_in,
	input  wire logic [2:0]    kb_set_match_in,
	input  wire logic          kb_os_key_in,
	input  wire logic          ms_move_in,
	input  wire logic          ms_left_click_in,
	input  wire logic          ms_right_click_in,
	input  wire logic          ms_left_dbl_in,
	input  wire logic          ms_right_dbl_in,
	// Power outputs
	output logic               power_switch_out_n,
	output logic               power_good_intermediate_stage,
	output logic               power_good_out,
	output logic               secondary_power_good_out,
	output logic               standby_gate_out_n,
	output logic               chassis_intrusion,
	// Reset source outputs
	output logic               voltage_id_reset_n,
	output logic               gpio22_reset_n,
	output logic               gpio23_reset_n,
	output logic               watchdog_reset_n,
	output logic               hwmon_reset_n
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
		hit = (a[AW-1:2] == idx);
	endfunction : hit

	// Released reset level for one consumer
	function automatic logic pick(input logic sel_pg, input logic pg, input logic bus_n);
		pick = sel_pg ? pg : bus_n;
	endfunction : pick

	// ****************************************
	// Pin synchronisers and edges
	// ****************************************
	localparam int NP = 16;
	logic [NP-1:0] pin_s;
	logic [NP-1:0] pin_d_reg;
	logic [NP-1:0] rise;
	plwr_sync #(.N(NP)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.pin_in   ({ms_right_dbl_in, ms_left_dbl_in, ms_right_click_in, ms_left_click_in,
		            ms_move_in, kb_os_key_in, kb_set_match_in, kb_any_key_in,
		            chassis_intrusion_in, bus_reset_in_n, standby_return_in, system_on_in,
		            power_good_low_power_stage, supply_good_in}),
		.pin_sync (pin_s)
	);
	always_ff @(posedge aclk) begin
		if (!aresetn) pin_d_reg <= '0;
		else pin_d_reg <= pin_s;
	end
	assign rise = pin_s & ~pin_d_reg;

	logic sup_s, lp_s, son_s, bus_s;
	assign sup_s = pin_s[0];
	assign lp_s  = pin_s[1];
	assign son_s = pin_s[2];
	assign bus_s = pin_s[4];

	// ****************************************
	// Registers, by power domain
	// ****************************************
	logic       long_en_reg, last_off_reg, onp_en_reg, hwm_sel_reg, prev_on_reg;
	logic [1:0] mode_reg;
	logic       gate_en_reg, mdat_reg, cclr_reg, dly1_reg, kd3_reg, kd2_reg, osk_reg, wdt_sel_reg;
	logic [1:0] dly2_reg, msel_reg;
	logic [7:0] rsel_reg;
	logic       kb_any_reg, hunt_reg, trig_reg, kb_flag_reg, ms_flag_reg;
	logic       wr_en, rd_clr, kb_ev, ms_ev;
	logic [AW-1:0] wa_reg;
	logic [7:0] wd_reg;

	// Battery bits survive standby loss; only vbat_rst_n resets them
	always_ff @(posedge aclk) begin
		if (!vbat_rst_n) begin
			long_en_reg  <= 1'b0;
			mode_reg     <= PL_OFF;
			last_off_reg <= RST_SEQ[B_LAST];
			onp_en_reg   <= 1'b0;
			hwm_sel_reg  <= 1'b0;
			prev_on_reg  <= 1'b0;
		end else begin
			if (wr_en && hit(wa_reg, IDX_CTRL)) begin
				long_en_reg <= wd_reg[B_LONG];
				mode_reg    <= wd_reg[B_MODE +: 2];
			end
			if (wr_en && hit(wa_reg, IDX_SEQ)) last_off_reg <= wd_reg[B_LAST];
			if (wr_en && hit(wa_reg, IDX_KEY)) begin
				onp_en_reg  <= wd_reg[B_ONP];
				hwm_sel_reg <= wd_reg[B_HWM];
			end
			if (mode_reg == PL_RESTORE) prev_on_reg <= son_s;
		end
	end

	// Standby bits; kept while aresetn stays high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_en_reg <= 1'b0;
			rsel_reg    <= RST_RSEL;
			mdat_reg    <= RST_SEQ[B_MDAT];
			cclr_reg    <= RST_SEQ[B_CCLR];
			dly1_reg    <= RST_SEQ[B_DLY1];
			dly2_reg    <= RST_SEQ[B_DLY2 +: 2];
			{kd3_reg, kd2_reg, osk_reg, wdt_sel_reg} <= '0;
			msel_reg    <= '0;
		end else if (wr_en) begin
			if (hit(wa_reg, IDX_CTRL)) gate_en_reg <= wd_reg[B_GATE];
			else if (hit(wa_reg, IDX_RSEL)) rsel_reg <= wd_reg & 8'h1D;
			else if (hit(wa_reg, IDX_SEQ)) begin
				mdat_reg <= wd_reg[B_MDAT];
				cclr_reg <= wd_reg[B_CCLR];
				dly1_reg <= wd_reg[B_DLY1];
				dly2_reg <= wd_reg[B_DLY2 +: 2];
			end else if (hit(wa_reg, IDX_KEY)) begin
				kd3_reg     <= wd_reg[B_KD3];
				kd2_reg     <= wd_reg[B_KD2];
				osk_reg     <= wd_reg[B_OSK];
				wdt_sel_reg <= wd_reg[B_WDT];
			end else if (hit(wa_reg, IDX_MOUSE)) msel_reg <= {wd_reg[B_MSR], wd_reg[B_MSX]};
		end
	end

	// Bus-reset bits; a capture clears hunting even against a write
	always_ff @(posedge aclk) begin
		if (!aresetn || !bus_s) begin
			kb_any_reg <= 1'b0;
			hunt_reg   <= 1'b0;
		end else begin
			if (wr_en && hit(wa_reg, IDX_CTRL)) begin
				kb_any_reg <= wd_reg[B_KBANY];
				hunt_reg   <= wd_reg[B_HUNT];
			end
			if (hunt_reg && (kb_ev || ms_ev)) hunt_reg <= 1'b0;
		end
	end

	// Retrigger strobe reads back as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) trig_reg <= 1'b0;
		else trig_reg <= wr_en && hit(wa_reg, IDX_SEQ) && wd_reg[B_TRIG];
	end

	// ****************************************
	// Wake events
	// ****************************************
	always_comb begin
		kb_ev = (kb_any_reg ? rise[6]
			: (rise[7] || (rise[8] && kd2_reg) || (rise[9] && kd3_reg)))
			|| (osk_reg && rise[10]);
		case ({mdat_reg, msel_reg})
			3'b101, 3'b111: ms_ev = rise[11] || rise[12] || rise[13];
			3'b100, 3'b110: ms_ev = rise[12] || rise[13];
			3'b001:         ms_ev = rise[12];
			3'b000:         ms_ev = rise[14];
			default:        ms_ev = rise[15];
		endcase
	end

	// Flags: a capture wins over the read that clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			kb_flag_reg <= 1'b0;
			ms_flag_reg <= 1'b0;
		end else begin
			kb_flag_reg <= (hunt_reg && kb_ev) || (kb_flag_reg && !rd_clr);
			ms_flag_reg <= (hunt_reg && ms_ev) || (ms_flag_reg && !rd_clr);
		end
	end

	// ****************************************
	// Power return and power-switch pulses
	// ****************************************
	plwr_tmr_if pl_if ();
	plwr_timer u_pulse (.aclk(aclk), .aresetn(aresetn), .t(pl_if));
	logic res_on, go_long, go_on, go_wake;
	always_comb begin
		case (mode_reg)
			PL_OFF:     res_on = 1'b0;
			PL_ON:      res_on = 1'b1;
			PL_RESTORE: res_on = prev_on_reg;
			default:    res_on = !last_off_reg;
		endcase
	end
	assign go_long = rise[3] && !res_on && long_en_reg;
	assign go_on   = rise[3] && res_on && onp_en_reg;
	assign go_wake = hunt_reg && kb_ev && !pl_if.busy;

	// Power return outranks a wake press
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pl_if.load  <= 1'b0;
			pl_if.count <= '0;
		end else begin
			pl_if.load <= go_long || go_on || go_wake;
			if (go_long) pl_if.count <= TW'(LONG_CYC);
			else if (go_on) pl_if.count <= TW'(ON_CYC);
			else if (go_wake) pl_if.count <= TW'(WAKE_CYC);
		end
	end

	// ****************************************
	// Power-good sequencer
	// ****************************************
	plwr_tmr_if sq_if ();
	plwr_timer u_seq (.aclk(aclk), .aresetn(aresetn), .t(sq_if));
	plwr_seq_type st_reg;
	logic gate_ok;
	logic [TW-1:0] d2_cyc;
	assign gate_ok = rsel_reg[B_PGDIS] || sup_s;
	always_comb begin
		case (dly2_reg)
			DLY2_A:  d2_cyc = TW'(D2A_CYC);
			DLY2_B:  d2_cyc = TW'(D2B_CYC);
			default: d2_cyc = TW'(D2C_CYC);
		endcase
	end

	// Any loss of gating or a retrigger restarts from idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg      <= SQ_IDLE;
			sq_if.load  <= 1'b0;
			sq_if.count <= '0;
		end else begin
			sq_if.load <= 1'b0;
			if (trig_reg || !gate_ok || !lp_s) begin
				st_reg <= SQ_IDLE;
			end else begin
				case (st_reg)
					SQ_IDLE: begin
						st_reg      <= SQ_STAGE1;
						sq_if.load  <= 1'b1;
						sq_if.count <= dly1_reg ? TW'(D1F_CYC) : TW'(D1S_CYC);
					end
					SQ_STAGE1: if (sq_if.done) begin
						if (dly2_reg == DLY2_NONE) st_reg <= SQ_ON;
						else begin
							st_reg      <= SQ_STAGE2;
							sq_if.load  <= 1'b1;
							sq_if.count <= d2_cyc;
						end
					end
					SQ_STAGE2: if (sq_if.done) st_reg <= SQ_ON;
					default: st_reg <= SQ_ON;
				endcase
			end
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_switch_out_n            <= 1'b1;
			power_good_intermediate_stage <= 1'b0;
			power_good_out                <= 1'b0;
			secondary_power_good_out      <= 1'b0;
			standby_gate_out_n            <= 1'b1;
		end else begin
			power_switch_out_n            <= !pl_if.busy;
			power_good_intermediate_stage <= (st_reg == SQ_STAGE2) || (st_reg == SQ_ON);
			power_good_out                <= (st_reg == SQ_ON);
			secondary_power_good_out      <= (st_reg == SQ_ON);
			standby_gate_out_n            <= !(gate_en_reg && son_s);
		end
	end

	// Chassis status; a new intrusion wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) chassis_intrusion <= 1'b0;
		else if (rise[5]) chassis_intrusion <= 1'b1;
		else if (cclr_reg) chassis_intrusion <= 1'b0;
	end

	// Reset sources follow power-good or the bus reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{voltage_id_reset_n, gpio22_reset_n, gpio23_reset_n} <= '0;
			{watchdog_reset_n, hwmon_reset_n} <= '0;
		end else begin
			voltage_id_reset_n <= pick(rsel_reg[B_VID], power_good_out, bus_s);
			gpio23_reset_n     <= pick(rsel_reg[B_GP23], power_good_out, bus_s);
			gpio22_reset_n     <= pick(rsel_reg[B_GP22], power_good_out, bus_s);
			watchdog_reset_n   <= pick(wdt_sel_reg, power_good_out, bus_s);
			hwmon_reset_n      <= pick(!hwm_sel_reg, power_good_out, bus_s);
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	// Address and data are held until both arrived
	assign wr_en  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign rd_clr = s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, IDX_STAT);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			wa_reg        <= '0;
			wd_reg        <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wa_reg        <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wd_reg       <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			end
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (hit(wa_reg, IDX_CTRL) || hit(wa_reg, IDX_RSEL) || hit(wa_reg, IDX_SEQ)
					|| hit(wa_reg, IDX_KEY) || hit(wa_reg, IDX_MOUSE)) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			if (hit(s_axi_araddr, IDX_CTRL))
				s_axi_rdata <= {24'h0, long_en_reg, mode_reg, gate_en_reg, kb_any_reg, hunt_reg, 2'h0};
			else if (hit(s_axi_araddr, IDX_RSEL)) s_axi_rdata <= {24'h0, rsel_reg};
			else if (hit(s_axi_araddr, IDX_SEQ))
				s_axi_rdata <= {24'h0, mdat_reg, 1'b0, cclr_reg, last_off_reg, dly1_reg, dly2_reg, 1'b0};
			else if (hit(s_axi_araddr, IDX_KEY))
				s_axi_rdata <= {24'h0, kd3_reg, kd2_reg, osk_reg, onp_en_reg, wdt_sel_reg, 2'h0, hwm_sel_reg};
			else if (hit(s_axi_araddr, IDX_MOUSE))
				s_axi_rdata <= {24'h0, 3'h0, msel_reg[1], 2'h0, msel_reg[0], 1'b0};
			else if (hit(s_axi_araddr, IDX_STAT))
				s_axi_rdata <= {24'h0, 4'h0, power_good_out, chassis_intrusion, ms_flag_reg, kb_flag_reg};
			else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !vbat_rst_n);
	a_long_pulse_low:   assert property (go_long |-> ##3 !power_switch_out_n)
		else $error("long pulse missing");
	a_on_pulse_low:     assert property (go_on && !go_long |-> ##3 !power_switch_out_n)
		else $error("on-return pulse missing");
	a_mode_resolve:     assert property (mode_reg == PL_OFF |-> !go_on)
		else $error("off mode produced on pulse");
	a_user_last_state:  assert property (rise[3] && mode_reg == PL_USER && onp_en_reg && !last_off_reg |-> go_on)
		else $error("last-state flag ignored");
	a_hunt_clear:       assert property (hunt_reg && (kb_ev || ms_ev) && bus_s |=> !hunt_reg)
		else $error("hunting not cleared");
	a_kb_flag_set:      assert property (hunt_reg && kb_ev |=> kb_flag_reg)
		else $error("keyboard flag not latched");
	a_read_clear:       assert property (rd_clr && !(hunt_reg && ms_ev) |=> !ms_flag_reg)
		else $error("mouse flag not cleared by read");
	a_chassis_clear:    assert property (cclr_reg && !rise[5] |=> !chassis_intrusion)
		else $error("chassis status not cleared");
	a_supply_gate:      assert property (!gate_ok |-> ##2 !power_good_out && !secondary_power_good_out)
		else $error("power-good not gated");
	a_retrigger_drop:   assert property (trig_reg |-> ##2 !power_good_out)
		else $error("retrigger did not drop power-good");
	a_no_second_delay:  assert property (st_reg == SQ_STAGE1 && sq_if.done && dly2_reg == DLY2_NONE
		&& gate_ok && lp_s && !trig_reg |=> st_reg == SQ_ON)
		else $error("zero second delay not honoured");
	a_wdt_source:       assert property (##1 watchdog_reset_n == $past(wdt_sel_reg ? power_good_out : bus_s))
		else $error("watchdog reset source wrong");
	c_long_pulse:       cover property (go_long ##3 !power_switch_out_n);
	c_power_good_up:    cover property (!power_good_out ##1 power_good_out);
	c_kb_wake:          cover property (hunt_reg && kb_ev ##1 kb_flag_reg);
	c_retrigger:        cover property (power_good_out && trig_reg);
endmodule : plwr_ctrl
`default_nettype wire

// ==== pkg/plwr_pkg.sv ====
// ****************************************
// Shared constants of the power-loss, wake and reset control block
// ****************************************
package plwr_pkg;
	// Clock rate and time units
	localparam int CLK_HZ        = 10_000_000;
	localparam int MS_PER_S      = 1000;
	localparam int CYC_PER_MS    = CLK_HZ / MS_PER_S;
	// Pulse and delay times, as printed
	localparam int LONG_PULSE_S  = 4;
	localparam int ON_PULSE_MS   = 500;
	localparam int WAKE_PULSE_MS = 100;
	localparam int DLY1_SLOW_MS  = 300;
	localparam int DLY1_FAST_MS  = 200;
	localparam int DLY2_A_MS     = 32;
	localparam int DLY2_B_MS     = 96;
	localparam int DLY2_C_MS     = 250;
	// Derived cycle counts (least times, whole periods)
	localparam int LONG_PULSE_CYC = LONG_PULSE_S * CLK_HZ;
	localparam int ON_PULSE_CYC   = ON_PULSE_MS * CYC_PER_MS;
	localparam int WAKE_PULSE_CYC = WAKE_PULSE_MS * CYC_PER_MS;
	localparam int DLY1_SLOW_CYC  = DLY1_SLOW_MS * CYC_PER_MS;
	localparam int DLY1_FAST_CYC  = DLY1_FAST_MS * CYC_PER_MS;
	localparam int DLY2_A_CYC     = DLY2_A_MS * CYC_PER_MS;
	localparam int DLY2_B_CYC     = DLY2_B_MS * CYC_PER_MS;
	localparam int DLY2_C_CYC     = DLY2_C_MS * CYC_PER_MS;
	localparam int TW             = 26;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_MOUSE = 8'hE0;
	localparam logic [7:0] IDX_STAT  = 8'hE3;
	localparam logic [7:0] IDX_CTRL  = 8'hE4;
	localparam logic [7:0] IDX_RSEL  = 8'hE5;
	localparam logic [7:0] IDX_SEQ   = 8'hE6;
	localparam logic [7:0] IDX_KEY   = 8'hE7;
	localparam int AW = 10;
	// Reset values
	localparam logic [7:0] RST_RSEL = 8'h00;
	localparam logic [7:0] RST_SEQ  = 8'h1C;
	// Field positions
	localparam int B_LONG = 7, B_MODE = 5, B_GATE = 4, B_KBANY = 3, B_HUNT = 2;
	localparam int B_VID = 4, B_GP23 = 3, B_GP22 = 2, B_PGDIS = 0;
	localparam int B_MDAT = 7, B_CCLR = 5, B_LAST = 4, B_DLY1 = 3, B_DLY2 = 1, B_TRIG = 0;
	localparam int B_KD3 = 7, B_KD2 = 6, B_OSK = 5, B_ONP = 4, B_WDT = 3, B_HWM = 0;
	localparam int B_MSR = 4, B_MSX = 1;
	// Power-loss modes
	localparam logic [1:0] PL_OFF = 2'h0, PL_ON = 2'h1, PL_RESTORE = 2'h2, PL_USER = 2'h3;
	localparam logic [1:0] DLY2_NONE = 2'h0, DLY2_A = 2'h1, DLY2_B = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SQ_IDLE, SQ_STAGE1, SQ_STAGE2, SQ_ON} plwr_seq_type;
endpackage : plwr_pkg

// ==== pkg/plwr_tmr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Load and done lines of one down-counter
// ****************************************
interface plwr_tmr_if;
	import plwr_pkg::*;
	logic          load;
	logic [TW-1:0] count;
	logic          busy;
	logic          done;
	modport ctrl (output load, output count, input busy, input done);
	modport tmr  (input load, input count, output busy, output done);
endinterface : plwr_tmr_if
`default_nettype wire

// ==== logic/plwr_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module plwr_sync
	import plwr_pkg::*;
#(
	parameter int N = 1
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Pins in, synchronised out
	input  wire logic [N-1:0] pin_in,
	output logic      [N-1:0] pin_sync
);
	logic [N-1:0] meta_reg;

	// Two stages; first stage read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '0;
			pin_sync <= '0;
		end else begin
			meta_reg <= pin_in;
			pin_sync <= meta_reg;
		end
	end
endmodule : plwr_sync
`default_nettype wire

// ==== logic/plwr_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module plwr_timer
	import plwr_pkg::*;
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Control side
	plwr_tmr_if.tmr   t
);
	logic [TW-1:0] cnt_reg;

	// Loaded count runs down once per clock period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= '0;
		end else if (t.load) begin
			cnt_reg <= t.count;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - TW'(1);
		end
	end

	// Done marks the last busy cycle
	assign t.busy = (cnt_reg != '0);
	assign t.done = (cnt_reg == TW'(1));
endmodule : plwr_timer
`default_nettype wire

// ==== tb/plwr_psu.sv ====
`timescale 1ns/1ps
`default_nettype none
module plwr_psu (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Switch from the block
	input  wire logic power_switch_out_n,
	// Supply state back
	output logic      system_on_in,
	output logic      supply_good_in
);
	logic sw_reg;
	// Power flips when a switch pulse ends; supply good lags a cycle
	always_ff @(posedge aclk) begin
		sw_reg <= power_switch_out_n;
		supply_good_in <= system_on_in;
		if (!aresetn) begin
			sw_reg <= 1'h1;
			system_on_in <= 1'h0;
		end else if (power_switch_out_n && !sw_reg) begin
			system_on_in <= !system_on_in;
		end
	end
endmodule : plwr_psu
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import plwr_pkg::*;
	logic          aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic          arvalid = 0, rready = 0, sr = 0, lp = 0, kb = 0, mv = 0, ci = 0;
	logic [AW-1:0] awaddr = '0, araddr = '0;
	logic [31:0]   wdata = '0, rdata, w;
	logic [1:0]    bresp, rresp;
	logic          awready, wready, bvalid, arready, rvalid, psw_n, son, sgood, pg, pgi, chi, vid_n;
	logic [2:0]    km = '0, md = '0;
	logic          pg2, sgate_n, g22_n, g23_n, wdt_n, hwm_n;
	logic [7:0]    pc[5] = '{8'h80, 8'hA0, 8'hE0, 8'hE0, 8'hC0};
	logic [7:0]    ps[5] = '{8'h1C, 8'h1C, 8'h10, 8'h00, 8'h00};
	int            pe[5] = '{20, 10, 20, 10, 20};
	int            err_total = 0, compares = 0, n;
	// Free-running 10 MHz clock
	always #50 aclk = !aclk;
	plwr_psu i_plwr_psu (.aclk, .aresetn, .power_switch_out_n(psw_n), .system_on_in(son), .supply_good_in(sgood));
	plwr_ctrl #(.LONG_CYC(20), .ON_CYC(10), .WAKE_CYC(5), .D1S_CYC(30), .D1F_CYC(20), .D2A_CYC(4),
		.D2B_CYC(8), .D2C_CYC(12)) i_plwr_ctrl (.aclk, .aresetn, .vbat_rst_n(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .supply_good_in(sgood), .power_good_low_power_stage(lp),
		.system_on_in(son), .standby_return_in(sr), .bus_reset_in_n(aresetn), .chassis_intrusion_in(ci),
		.kb_any_key_in(kb), .kb_set_match_in(km), .kb_os_key_in(kb), .ms_move_in(mv),
		.ms_left_click_in(mv), .ms_right_click_in(md[0]), .ms_left_dbl_in(md[1]), .ms_right_dbl_in(md[2]),
		.power_switch_out_n(psw_n), .power_good_intermediate_stage(pgi), .power_good_out(pg),
		.secondary_power_good_out(pg2), .standby_gate_out_n(sgate_n), .chassis_intrusion(chi),
		.voltage_id_reset_n(vid_n), .gpio22_reset_n(g22_n), .gpio23_reset_n(g23_n), .watchdog_reset_n(wdt_n),
		.hwmon_reset_n(hwm_n));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	// A wait that ran out ends the run as a failure
	task automatic tmo(input int k);
		if (k >= 99) begin
			err_total++;
			stop_test;
		end
	endtask : tmo
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		@(posedge aclk);
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, v};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
		tmo(n);
	endtask : wr
	task automatic rc(input logic [7:0] i, input logic [7:0] e, input logic [1:0] s);
		@(posedge aclk);
		araddr <= {i, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		chk(rdata, {24'h0, e});
		chk({30'h0, rresp}, {30'h0, s});
		rready <= 1'h0;
		tmo(n);
	endtask : rc
	// Width of the next low pulse on the power switch
	task automatic pw;
		w = 0;
		for (n = 0; n < 60 && psw_n; n++) @(posedge aclk);
		while (!psw_n && w < 99) begin
			@(posedge aclk);
			w++;
		end
	endtask : pw
	// Count cycles until power good rises
	task automatic pgw;
		for (n = 0; n < 99 && pg !== 1'h1; n++) @(posedge aclk);
	endtask : pgw
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		for (int k = 0; k < 4; k++) rc(IDX_CTRL + k, 8'(32'h001C0000 >> (8 * k)), RESP_OKAY);
		rc(8'hF0, 8'h00, RESP_SLVERR);
		wr(IDX_RSEL, 8'hFF);
		rc(IDX_RSEL, 8'h1D, RESP_OKAY);
		wr(IDX_KEY, 8'h10);
		// Each power-loss mode in turn, partner flips power on each pulse
		for (int k = 0; k < 5; k++) begin
			wr(IDX_CTRL, pc[k]);
			wr(IDX_SEQ, ps[k]);
			sr <= 1'h0;
			repeat (4) @(posedge aclk);
			sr <= 1'h1;
			pw;
			chk(w, pe[k]);
		end
		wr(IDX_CTRL, 8'h0C);
		kb <= 1'h1;
		pw;
		chk(w, 5);
		rc(IDX_CTRL, 8'h08, RESP_OKAY);
		rc(IDX_STAT, 8'h01, RESP_OKAY);
		rc(IDX_STAT, 8'h00, RESP_OKAY);
		wr(IDX_SEQ, 8'h80);
		wr(IDX_MOUSE, 8'h02);
		wr(IDX_CTRL, 8'h04);
		mv <= 1'h1;
		repeat (6) @(posedge aclk);
		rc(IDX_STAT, 8'h02, RESP_OKAY);
		rc(IDX_CTRL, 8'h00, RESP_OKAY);
		wr(IDX_SEQ, 8'h02);
		lp <= 1'h1;
		pgw;
		chk(32'(n >= 34 && n < 99), 1);
		repeat (3) @(posedge aclk);
		chk({pgi, vid_n}, 2'h3);
		chk({pg2, g22_n, g23_n, wdt_n, hwm_n, sgate_n}, 6'h3F);
		wr(IDX_SEQ, 8'h03);
		repeat (3) @(posedge aclk);
		pgw;
		chk(32'(n >= 25 && n < 99), 1);
		rc(IDX_SEQ, 8'h02, RESP_OKAY);
		ci <= 1'h1;
		repeat (5) @(posedge aclk);
		chk(chi, 1);
		wr(IDX_SEQ, 8'h22);
		repeat (2) @(posedge aclk);
		chk(chi, 0);
		wr(IDX_SEQ, 8'h02);
		stop_test;
	end
endmodule : tb
`default_nettype wire
